/* File: nand_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_defs.svh"

module nand_host
  import nand_host_pkg::*;
#(
  parameter bit WIDE = 1'b0
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // user request port
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [2:0] REQ_KIND,
  input wire logic [15:0] REQ_DATA,
  input wire logic [24:0] REQ_ADDR,
  input wire logic PROTECT,
  // user answer port
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic BUSY,
  // flash pins
  output logic NAND_CE_N,
  output logic NAND_CLE,
  output logic NAND_ALE,
  output logic NAND_WE_N,
  output logic NAND_READ_STROBE_N,
  output logic NAND_WP_N,
  input wire logic [15:0] IO_BUS_IN,
  output logic [15:0] IO_BUS_OUT,
  output logic IO_BUS_OE,
  input wire logic RB_N_IN
);

  localparam logic [3:0] SETUP_N = 4'(`NB_SETUP_CYC - 1);
  localparam logic [3:0] PULSE_N = 4'(`NB_PULSE_CYC - 1);
  localparam logic [3:0] HOLD_N = 4'(`NB_HOLD_CYC - 1);
  localparam logic [3:0] READ_N = 4'(`NB_READ_ACCESS_DELAY_CYC + `NB_SYNC_CYC - 1);
  localparam logic [3:0] GUARD_N = 4'(`NB_BUSY_GUARD_CYC + `NB_SYNC_CYC - 1);

  host_state_t r_q;
  host_state_t r_d;
  logic [16:0] pins_s;
  logic rdy_s;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  nand_pin_sync u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({IO_BUS_IN, RB_N_IN}),
    .Q(pins_s)
  );
  // ready/busy keeps meaning even with the chip deselected
  assign rdy_s = pins_s[0];

  // ----------------------------------------------------------------
  // address cycle byte
  // ----------------------------------------------------------------
  // column bit 8 never leaves the host: the read command selects it
  function automatic logic [15:0] addr_byte(input logic [24:0] a, input logic [1:0] c);
    logic [15:0] b;
    b = 16'h0000;
    unique case (c)
      2'h0: b[7:0] = a[7:0];
      2'h1: b[7:0] = a[15:8];
      2'h2: b[7:0] = a[23:16];
      2'h3: b[0] = a[24];
    endcase
    return b;
  endfunction : addr_byte

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    r_d.wp_n = ~PROTECT;
    unique case (r_q.st)
      S_IDLE:
      begin
        if (REQ_VALID)
        begin
          r_d.kind = kind_t'(REQ_KIND);
          r_d.addr = REQ_ADDR;
          r_d.acnt = 3'h0;
          r_d.ce_n = 1'b0;
          r_d.cnt = SETUP_N;
          r_d.st = S_SETUP;
          r_d.oe = 1'b1;
          r_d.cle = 1'b0;
          r_d.ale = 1'b0;
          unique case (kind_t'(REQ_KIND))
            K_CMD:
            begin
              r_d.cle = 1'b1;
              r_d.dout = {8'h00, REQ_DATA[7:0]};
            end
            K_ADDR4:
            begin
              r_d.ale = 1'b1;
              r_d.cyc = `NB_ADDR_COL_FIRST_CYC;
              r_d.dout = addr_byte(REQ_ADDR, `NB_ADDR_COL_FIRST_CYC);
            end
            K_ADDR3:
            begin
              // erase takes only the three row cycles
              r_d.ale = 1'b1;
              r_d.cyc = `NB_ADDR_ROW_FIRST_CYC;
              r_d.dout = addr_byte(REQ_ADDR, `NB_ADDR_ROW_FIRST_CYC);
            end
            K_WRITE:
            begin
              // in x8 the upper lines stay low rather than floating
              r_d.dout = WIDE ? REQ_DATA : {8'h00, REQ_DATA[7:0]};
            end
            K_READ:
            begin
              r_d.oe = 1'b0;
            end
            default:
            begin
              // unknown kinds are taken as a wait for ready
              r_d.oe = 1'b0;
              r_d.kind = K_WAIT;
              r_d.cnt = GUARD_N;
              r_d.st = S_WAIT;
            end
          endcase
        end
        else
        begin
          r_d.ce_n = 1'b1;
        end
      end
      S_SETUP:
      begin
        if (r_q.cnt == 4'h0)
        begin
          r_d.st = S_LOW;
          r_d.cnt = (r_q.kind == K_READ) ? READ_N : PULSE_N;
          if (r_q.kind == K_READ)
          begin
            r_d.read_strobe_n = 1'b0;
          end
          else
          begin
            r_d.we_n = 1'b0;
          end
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      S_LOW:
      begin
        if (r_q.cnt == 4'h0)
        begin
          // data is sampled before the read strobe rises, after access delay
          if (r_q.kind == K_READ)
          begin
            r_d.rdata = WIDE ? pins_s[16:1] : {8'h00, pins_s[8:1]};
          end
          r_d.we_n = 1'b1;
          r_d.read_strobe_n = 1'b1;
          r_d.cnt = HOLD_N;
          r_d.st = S_HIGH;
          if (r_q.ale)
          begin
            r_d.acnt = r_q.acnt + 3'h1;
          end
        end
        else
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      S_HIGH:
      begin
        if (r_q.cnt != 4'h0)
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
        else if (r_q.ale && r_q.cyc != `NB_ADDR_LAST_CYC)
        begin
          // next address cycle keeps ALE high, no fresh setup
          r_d.cyc = r_q.cyc + 2'h1;
          r_d.dout = addr_byte(r_q.addr, r_q.cyc + 2'h1);
          r_d.cnt = PULSE_N;
          r_d.we_n = 1'b0;
          r_d.st = S_LOW;
        end
        else
        begin
          r_d.oe = 1'b0;
          r_d.cle = 1'b0;
          r_d.ale = 1'b0;
          r_d.rvalid = (r_q.kind == K_READ);
          r_d.st = S_IDLE;
        end
      end
      S_WAIT:
      begin
        // guard first: ready/busy falls only some time after the command
        if (r_q.cnt != 4'h0)
        begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
        else if (rdy_s)
        begin
          r_d.st = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r_q <= '{st: S_IDLE, kind: K_CMD, cnt: 4'h0, cyc: 2'h0, addr: 25'h0000000,
               dout: 16'h0000, oe: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
               read_strobe_n: 1'b1, ce_n: 1'b1, wp_n: 1'b0, rdata: 16'h0000,
               rvalid: 1'b0, acnt: 3'h0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REQ_READY = (r_q.st == S_IDLE);
  assign RSP_VALID = r_q.rvalid;
  assign RSP_DATA = r_q.rdata;
  assign BUSY = ~rdy_s;
  assign NAND_CE_N = r_q.ce_n;
  assign NAND_CLE = r_q.cle;
  assign NAND_ALE = r_q.ale;
  assign NAND_WE_N = r_q.we_n;
  assign NAND_READ_STROBE_N = r_q.read_strobe_n;
  assign NAND_WP_N = r_q.wp_n;
  assign IO_BUS_OUT = r_q.dout;
  assign IO_BUS_OE = r_q.oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_upper_lines_low: assert property (@(posedge CLK) disable iff (RST)
    (IO_BUS_OE && (NAND_CLE || NAND_ALE)) |-> (IO_BUS_OUT[15:8] == 8'h00))
    else $error("upper io lines not low during command or address");

  a_cmd_latch_held: assert property (@(posedge CLK) disable iff (RST)
    ($rose(NAND_WE_N) && NAND_CLE) |-> ($past(NAND_CLE) && !NAND_ALE && IO_BUS_OE && !NAND_CE_N))
    else $error("command latch not held across write rise");

  a_addr_latch_held: assert property (@(posedge CLK) disable iff (RST)
    ($rose(NAND_WE_N) && NAND_ALE) |-> ($past(NAND_ALE) && !NAND_CLE && IO_BUS_OE))
    else $error("address latch not held across write rise");

  a_write_data_stands: assert property (@(posedge CLK) disable iff (RST)
    $fell(NAND_WE_N) |-> IO_BUS_OE ##1 (IO_BUS_OE && $stable(IO_BUS_OUT)))
    else $error("write data moved around write strobe");

  a_addr_map_first: assert property (@(posedge CLK) disable iff (RST)
    ($fell(NAND_WE_N) && NAND_ALE && r_q.cyc == 2'h1) |-> (IO_BUS_OUT[7:0] == r_q.addr[15:8]))
    else $error("second address cycle carries wrong page bits");

  a_fourth_cycle_low: assert property (@(posedge CLK) disable iff (RST)
    ($fell(NAND_WE_N) && NAND_ALE && r_q.cyc == 2'h3) |-> (IO_BUS_OUT == {15'h0000, r_q.addr[24]}))
    else $error("fourth address cycle unused lines not low");

  a_addr_count: assert property (@(posedge CLK) disable iff (RST)
    ($rose(REQ_READY) && $past(NAND_ALE)) |->
      (r_q.acnt == ((r_q.kind == K_ADDR4) ? 3'h4 : 3'h3)))
    else $error("wrong number of address cycles");

  a_data_word_write: assert property (@(posedge CLK) disable iff (RST)
    ($rose(NAND_WE_N) && !NAND_CLE && !NAND_ALE) |->
      (r_q.kind == K_WRITE && !NAND_CE_N && IO_BUS_OE && NAND_READ_STROBE_N))
    else $error("plain write strobe outside a data write");

endmodule : nand_host

`default_nettype wire

/* File: nand_host_defs.svh */
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

// ----------------------------------------------------------------
// clock and strobe timing
// ----------------------------------------------------------------
`define NB_CLK_MHZ 40
`define NB_SETUP_NS 15
`define NB_PULSE_NS 25
`define NB_HOLD_NS 15
`define NB_READ_ACCESS_DELAY_NS 30
`define NB_BUSY_GUARD_NS 100
// least times, rounded up to whole cycles
`define NB_SETUP_CYC ((`NB_SETUP_NS * `NB_CLK_MHZ + 999) / 1000)
`define NB_PULSE_CYC ((`NB_PULSE_NS * `NB_CLK_MHZ + 999) / 1000)
`define NB_HOLD_CYC ((`NB_HOLD_NS * `NB_CLK_MHZ + 999) / 1000)
`define NB_READ_ACCESS_DELAY_CYC ((`NB_READ_ACCESS_DELAY_NS * `NB_CLK_MHZ + 999) / 1000)
`define NB_BUSY_GUARD_CYC ((`NB_BUSY_GUARD_NS * `NB_CLK_MHZ + 999) / 1000)
// synchroniser depth on io_bus and ready/busy inputs
`define NB_SYNC_CYC 2

// ----------------------------------------------------------------
// address cycle layout
// ----------------------------------------------------------------
`define NB_ADDR_LAST_CYC 2'h3
`define NB_ADDR_ROW_FIRST_CYC 2'h1
`define NB_ADDR_COL_FIRST_CYC 2'h0

`endif

/* File: nand_host_pkg.sv */
package nand_host_pkg;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SETUP = 5'b00010,
    S_LOW   = 5'b00100,
    S_HIGH  = 5'b01000,
    S_WAIT  = 5'b10000
  } state_t;

  typedef enum logic [2:0] {
    K_CMD   = 3'h0,
    K_ADDR4 = 3'h1,
    K_ADDR3 = 3'h2,
    K_WRITE = 3'h3,
    K_READ  = 3'h4,
    K_WAIT  = 3'h5
  } kind_t;

  typedef struct packed {
    state_t st;
    kind_t kind;
    logic [3:0] cnt;
    logic [1:0] cyc;
    logic [24:0] addr;
    logic [15:0] dout;
    logic oe;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic ce_n;
    logic wp_n;
    logic [15:0] rdata;
    logic rvalid;
    logic [2:0] acnt;
  } host_state_t;

  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
  } sync_state_t;

endpackage : nand_host_pkg

/* File: nand_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module nand_pin_sync
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pins in, synchronised out
  input wire logic [16:0] D,
  output logic [16:0] Q
);

  sync_state_t r_q;
  sync_state_t r_d;

  // first stage feeds only the second stage
  always_comb
  begin
    r_d.s1 = D;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r_q.s1 <= 17'h00001;
      r_q.s2 <= 17'h00001;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign Q = r_q.s2;

endmodule : nand_pin_sync

`default_nettype wire

/* File: nand_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none

module nand_dev_model #(
  parameter int BUSY_NS = 1000,
  parameter int ACCESS_NS = 30
)
(
  // host pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [15:0] bus,
  // device drive
  output logic [15:0] dev_io,
  output logic rb_low
);
  logic [7:0] cmd_q;
  logic [15:0] aword [4];
  int acnt;
  int need;
  logic [8:0] col;
  logic [15:0] page [512];
  event op_go;

  initial
  begin
    dev_io = 16'h0000;
    rb_low = 1'b0;
    acnt = 0;
    need = 4;
    col = 9'h000;
    for (int i = 0; i < 512; i++)
      page[i] = {8'h00, i[7:0] ^ {i[8], 7'h43}};
  end

  // ----------------------------------------
  // write strobe: command, address, data
  // ----------------------------------------
  always @(posedge we_n)
    if (!ce_n && cle)
    begin
      cmd_q = bus[7:0];
      acnt = 0;
      need = (bus[7:0] == 8'h60) ? 3 : 4;
      col[8] = (bus[7:0] == 8'h01);
      if ((bus[7:0] == 8'h10 || bus[7:0] == 8'hd0) && wp_n)
        ->op_go;
    end
    else if (!ce_n && ale)
    begin
      if (acnt < need)
        aword[acnt] = bus;
      if (acnt == 0 && need == 4)
        col[7:0] = bus[7:0];
      acnt++;
    end
    else if (!ce_n)
    begin
      page[col] = bus;
      col++;
    end

  // ----------------------------------------
  // read strobe and bus release
  // ----------------------------------------
  always @(negedge read_strobe_n)
    if (!ce_n)
    begin
      dev_io <= #(ACCESS_NS) page[col];
      col++;
    end

  // no pull on the bus, so a released bus must not keep its last value
  always @(posedge read_strobe_n or posedge ce_n)
    dev_io <= ~dev_io;

  // busy runs on regardless of chip select
  always @(op_go)
  begin
    rb_low = 1'b1;
    #(BUSY_NS);
    rb_low = 1'b0;
  end
endmodule : nand_dev_model

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb
  import nand_host_pkg::*;
;
  logic clk, rst, req_valid, req_ready, protect, rsp_valid, busy, busy_seen;
  logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, rb_low, rb_n;
  logic [2:0] req_kind;
  logic [15:0] req_data, rsp_data, io_out, io_in, dev_io, got;
  logic [24:0] req_addr;
  int bad_count, samples_checked;

  assign io_in = io_oe ? io_out : dev_io;
  // ready/busy is pulled up on the board
  assign rb_n = rb_low ? 1'b0 : 1'b1;

  nand_host #(.WIDE(1'b0)) nand_host_inst (.CLK(clk), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_KIND(req_kind), .REQ_DATA(req_data), .REQ_ADDR(req_addr), .PROTECT(protect), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .BUSY(busy), .NAND_CE_N(ce_n), .NAND_CLE(cle), .NAND_ALE(ale), .NAND_WE_N(we_n),
    .NAND_READ_STROBE_N(read_strobe_n), .NAND_WP_N(wp_n), .IO_BUS_IN(io_in), .IO_BUS_OUT(io_out),
    .IO_BUS_OE(io_oe), .RB_N_IN(rb_n));

  nand_dev_model nand_dev_model_inst (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .bus(io_in), .dev_io(dev_io), .rb_low(rb_low));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // entered at a falling edge; returns at the falling edge where the sequencer is idle again
  task automatic req(input kind_t k, input logic [15:0] d, input logic [24:0] a);
    int n;
    n = 0;
    req_kind = k;
    req_data = d;
    req_addr = a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (req_ready !== 1'b1 && n < 400)
    begin
      if (busy === 1'b1)
        busy_seen = 1'b1;
      @(negedge clk);
      n++;
    end
    if (n >= 400)
    begin
      bad_count++;
      $display("unexpected at %0t: request never finished", $time);
    end
    got = rsp_data;
  endtask : req

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_program();
    protect = 1'b0;
    busy_seen = 1'b0;
    req(K_CMD, 16'h0080, '0);
    req(K_ADDR4, '0, 25'h1abcd02);
    req(K_WRITE, 16'h12a5, '0);
    req(K_WRITE, 16'h005a, '0);
    req(K_CMD, 16'h3410, '0);
    req(K_WAIT, '0, '0);
    chk(nand_dev_model_inst.aword[0], 16'h0002);
    chk(nand_dev_model_inst.aword[1], 16'h00cd);
    chk(nand_dev_model_inst.aword[2], 16'h00ab);
    chk(nand_dev_model_inst.aword[3], 16'h0001);
    chk(nand_dev_model_inst.page[2], 16'h00a5);
    chk(nand_dev_model_inst.page[3], 16'h005a);
    chk({8'h00, nand_dev_model_inst.cmd_q}, 16'h0010);
    chk({15'h0, busy_seen}, 16'h0001);
  endtask : t_program

  task automatic t_read();
    req(K_CMD, 16'h0000, '0);
    req(K_ADDR4, '0, 25'h0000002);
    // surplus address cycles must leave the address alone
    req(K_ADDR3, '0, 25'h1ffff00);
    chk(nand_dev_model_inst.aword[1], 16'h0000);
    req(K_READ, '0, '0);
    chk({15'h0, rsp_valid}, 16'h0001);
    chk(got, 16'h00a5);
    req(K_READ, '0, '0);
    chk(got, 16'h005a);
    req(K_CMD, 16'h0001, '0);
    req(K_ADDR4, '0, 25'h0000004);
    req(K_READ, '0, '0);
    chk(got, 16'h00c7);
  endtask : t_read

  task automatic t_erase(input logic p);
    protect = p;
    busy_seen = 1'b0;
    @(negedge clk);
    chk({15'h0, wp_n}, {15'h0, ~p});
    req(K_CMD, 16'h0060, '0);
    req(K_ADDR3, '0, 25'h0123400);
    // the closing command restarts the model's address count, so count first
    chk(16'(nand_dev_model_inst.acnt), 16'h0003);
    req(K_CMD, 16'h00d0, '0);
    req(K_WAIT, '0, '0);
    chk(nand_dev_model_inst.aword[0], 16'h0034);
    chk({15'h0, busy_seen}, {15'h0, ~p});
  endtask : t_erase

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_data = 16'h0000;
    req_addr = 25'h0000000;
    protect = 1'b0;
    busy_seen = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_program();
    t_read();
    t_erase(1'b1);
    t_erase(1'b0);
    report_and_stop();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #(25 * 5000);
    bad_count++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
